// File: rtsq_sequencer.sv
// Functional notes
// - Settle delay only after power-on or brown-out
// - Settle timer ticks from 31 kHz oscillator
// - Core held in reset while settle timer runs
// - Disable bit one turns settle timer off
// - Mode 01 lets software bit enable brown-out
// - Mode 10 disables brown-out during sleep
// - Brown-out longer than minimum resets device
// - Hold until supply good, then settle
// - Brown-out during settle restarts the timer
// - Power-on, settle, crystal count in order
// - Crystal modes wait 1024 oscillator periods
// - Other clock modes skip crystal count
// - Time-outs run independently of reset pin
// - Two-speed or fail-safe lets core run early
// - Brown-out flag in bit 0, cleared on brown-out
// - Brown-out flag don't-care when mode 00
// - Power-on flag bit 1 cleared on power-on
// - Power-on and brown-out set flag patterns
// - Watchdog and sleep resets set status flags
// - Power control resets to 01qq on power events, 00uu on watchdog or pin reset in run
// - Mode 11 on, 10 run-only, 01 soft, 00 off
`timescale 1ns/1ps
`include "rtsq_params.svh"
module rtsq_sequencer
   import rtsq_pkg::*;
#(
   parameter int SETTLE_TICKS = `RTSQ_SETTLE_TICKS,
   parameter int SLOW_DIV = `RTSQ_SLOW_DIV
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_n_i,
   input wire logic bod_i,
   input wire logic external_reset_pin_n_i,
   input wire logic wdt_reset_i,
   input wire logic wdt_wake_i,
   input wire logic int_wake_i,
   input wire logic sleep_req_i,
   input wire logic osc_tick_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic core_reset_o,
   output logic core_run_fast_o,
   output logic sleeping_o,
   output logic bod_enabled_o
);
   localparam int SDW = $clog2(SETTLE_TICKS + 1);
   localparam int DVW = $clog2(SLOW_DIV + 1);

   typedef struct packed {
      rtsq_pins_type s1;
      rtsq_pins_type s2;
      logic osc_prev;
      rtsq_state_type st;
      logic [DVW-1:0] div;
      logic [SDW-1:0] settle;
      logic [10:0] crystal_startup_count;
      logic [4:0] bod_cnt;
      logic bod_rst;
      logic pwr_event;
      logic por_flag;
      logic bor_flag;
      logic soft_brownout_enable;
      logic ultra_low_wake_enable;
      logic to_flag;
      logic pd_flag;
      logic [15:0] cfg;
      logic [2:0] cause;
      logic [31:0] rdat;
      logic ack;
      logic err;
   } rtsq_core_type;

   rtsq_core_type q_r, q_nxt;
   rtsq_pins_type pins;
   logic [2:0] osc_mode;
   logic [1:0] bor_mode;
   logic crystal, timer_on, bod_en, bod_q, slow_tick;
   logic wb_req, wr_power_control_flags, wr_stat, wr_cfg, hit;

   // Pins gathered into one carrier before synchronising
   assign pins = '{por_n: por_n_i, bod: bod_i, external_reset_pin_n: external_reset_pin_n_i,
                   wdt_reset: wdt_reset_i, wdt_wake: wdt_wake_i,
                   int_wake: int_wake_i, sleep_req: sleep_req_i,
                   osc_tick: osc_tick_i};

   // Configuration decode
   assign osc_mode = q_r.cfg[`RTSQ_CFG_OSC_LSB +: 3];
   assign bor_mode = q_r.cfg[`RTSQ_CFG_BROWNOUT_MODE_SELECT_LSB +: 2];
   assign crystal = (osc_mode <= 3'h2); // LP, XT, HS need CRYSTAL_STARTUP_COUNT
   assign timer_on = ~q_r.cfg[`RTSQ_CFG_SUPPLY_TIMER_DISABLE_BIT];

   // Brown-out enable per mode
   always_comb begin
      unique case (bor_mode)
         2'h3: bod_en = 1'b1;
         2'h2: bod_en = (q_r.st != RTSQ_SLEEP);
         2'h1: bod_en = q_r.soft_brownout_enable;
         2'h0: bod_en = 1'b0;
      endcase
   end
   // Only the second synchroniser stage is read
   assign bod_q = q_r.s2.bod & bod_en;
   assign slow_tick = (q_r.div == DVW'(SLOW_DIV - 1));

   // Bus decode; ack is one cycle, dropped the cycle after
   assign wb_req = wb_cyc_i & wb_stb_i & ~q_r.ack & ~q_r.err;
   assign hit = (wb_adr_i == `RTSQ_ADDR_PWRCTL) ||
                (wb_adr_i == `RTSQ_ADDR_STATUS) ||
                (wb_adr_i == `RTSQ_ADDR_CONFIG) ||
                (wb_adr_i == `RTSQ_ADDR_CAUSE);
   assign wr_power_control_flags = wb_req & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i == `RTSQ_ADDR_PWRCTL);
   assign wr_stat = wb_req & wb_we_i & wb_sel_i[0] &
                    (wb_adr_i == `RTSQ_ADDR_STATUS);
   assign wr_cfg = wb_req & wb_we_i & (wb_adr_i == `RTSQ_ADDR_CONFIG);

   // Next-state logic for the whole block
   always_comb begin
      logic por_ev, bor_ev, leave_hold;
      por_ev = 1'b0;
      bor_ev = 1'b0;
      leave_hold = 1'b0;
      q_nxt = q_r;
      q_nxt.s1 = pins;
      q_nxt.s2 = q_r.s1;
      q_nxt.osc_prev = q_r.s2.osc_tick;
      q_nxt.ack = 1'b0;
      q_nxt.err = 1'b0;
      q_nxt.div = slow_tick ? '0 : DVW'(q_r.div + 1'b1);

      // Minimum-duration filter on brown-out
      if (!bod_q) begin
         q_nxt.bod_cnt = '0;
      end else if (q_r.bod_cnt != 5'(`RTSQ_BOD_MIN_CYC)) begin
         q_nxt.bod_cnt = q_r.bod_cnt + 5'h01;
      end
      q_nxt.bod_rst = (q_r.bod_cnt == 5'(`RTSQ_BOD_MIN_CYC));

      // Power-on and brown-out restart the sequence
      if (!q_r.s2.por_n) begin
         por_ev = 1'b1;
      end else if (q_r.bod_rst) begin
         bor_ev = 1'b1;
      end

      unique case (q_r.st)
         RTSQ_HOLD: begin
            // Wait for supply above threshold
            if (!por_ev && !bor_ev && !q_r.s2.bod) begin
               leave_hold = 1'b1;
            end
         end
         RTSQ_SETTLE: begin
            // Counts slow ticks only while holding the core
            if (slow_tick) begin
               q_nxt.settle = SDW'(q_r.settle + 1'b1);
            end
            if (q_r.settle == SDW'(SETTLE_TICKS)) begin
               q_nxt.crystal_startup_count = '0;
               q_nxt.st = crystal ? RTSQ_OST : RTSQ_RUN;
            end
         end
         RTSQ_OST: begin
            // Count oscillator periods on tick rising edges
            if (q_r.s2.osc_tick && !q_r.osc_prev) begin
               q_nxt.crystal_startup_count = q_r.crystal_startup_count + 11'h001;
            end
            if (q_r.crystal_startup_count == 11'(`RTSQ_OST_PERIODS)) begin
               q_nxt.st = RTSQ_RUN;
            end
         end
         RTSQ_RUN: begin
            if (q_r.s2.sleep_req) begin
               q_nxt.st = RTSQ_SLEEP;
               q_nxt.pd_flag = 1'b0;
            end
         end
         RTSQ_SLEEP: begin
            // Wake-ups resume; crystal restarts with CRYSTAL_STARTUP_COUNT only
            if (q_r.s2.wdt_wake || q_r.s2.int_wake) begin
               q_nxt.crystal_startup_count = '0;
               q_nxt.st = crystal ? RTSQ_OST : RTSQ_RUN;
               if (q_r.s2.wdt_wake) begin
                  q_nxt.to_flag = 1'b0;
                  q_nxt.pd_flag = 1'b0;
               end
            end
         end
         default: q_nxt.st = RTSQ_HOLD;
      endcase

      // Other reset causes: no settle delay
      if (q_r.st == RTSQ_SLEEP && !q_r.s2.external_reset_pin_n) begin
         q_nxt.to_flag = 1'b1;
         q_nxt.pd_flag = 1'b0;
         q_nxt.cause = 3'h5;
         q_nxt.crystal_startup_count = '0;
         q_nxt.st = crystal ? RTSQ_OST : RTSQ_RUN;
      end else if (q_r.st == RTSQ_RUN && q_r.s2.wdt_reset) begin
         q_nxt.to_flag = 1'b0;
         q_nxt.cause = 3'h3;
         q_nxt.soft_brownout_enable = 1'b0; // Power control reads 00uu
         q_nxt.ultra_low_wake_enable = 1'b0;
      end else if (q_r.st == RTSQ_RUN && !q_r.s2.external_reset_pin_n) begin
         q_nxt.cause = 3'h4; // Flags unchanged
         q_nxt.soft_brownout_enable = 1'b0;
         q_nxt.ultra_low_wake_enable = 1'b0;
      end

      // Software writes; hardware events below take priority
      if (wr_power_control_flags) begin
         q_nxt.bor_flag = wb_dat_i[`RTSQ_POWER_CONTROL_FLAGS_BOR];
         q_nxt.por_flag = wb_dat_i[`RTSQ_POWER_CONTROL_FLAGS_POR];
         q_nxt.soft_brownout_enable = wb_dat_i[`RTSQ_POWER_CONTROL_FLAGS_SOFT_BROWNOUT_ENABLE];
         q_nxt.ultra_low_wake_enable = wb_dat_i[`RTSQ_POWER_CONTROL_FLAGS_ULTRA_LOW_WAKE_ENABLE];
      end
      if (wr_cfg) begin
         if (wb_sel_i[0]) begin
            q_nxt.cfg[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            q_nxt.cfg[15:8] = wb_dat_i[15:8];
         end
      end

      if (por_ev) begin
         q_nxt.st = RTSQ_HOLD;
         q_nxt.por_flag = 1'b0;
         q_nxt.to_flag = 1'b1;
         q_nxt.pd_flag = 1'b1;
         q_nxt.soft_brownout_enable = 1'b1; // Power control reads 01qq
         q_nxt.ultra_low_wake_enable = 1'b0;
         q_nxt.pwr_event = 1'b1;
         q_nxt.cause = 3'h1;
         q_nxt.settle = '0;
      end else if (bor_ev) begin
         q_nxt.st = RTSQ_HOLD;
         q_nxt.por_flag = 1'b1;
         q_nxt.bor_flag = 1'b0;
         q_nxt.to_flag = 1'b1;
         q_nxt.pd_flag = 1'b1;
         q_nxt.soft_brownout_enable = 1'b1;
         q_nxt.ultra_low_wake_enable = 1'b0;
         q_nxt.pwr_event = 1'b1;
         q_nxt.cause = 3'h2;
         q_nxt.settle = '0;
      end else if (leave_hold) begin
         // Settle only after power events and when enabled
         q_nxt.settle = '0;
         q_nxt.crystal_startup_count = '0;
         q_nxt.pwr_event = 1'b0;
         if (q_r.pwr_event && timer_on) begin
            q_nxt.st = RTSQ_SETTLE;
         end else begin
            q_nxt.st = crystal ? RTSQ_OST : RTSQ_RUN;
         end
      end

      // Register reads; unmapped addresses answer with err
      if (wb_req) begin
         q_nxt.ack = hit;
         q_nxt.err = ~hit;
         q_nxt.rdat = '0;
         unique case (wb_adr_i)
            `RTSQ_ADDR_PWRCTL: begin
               q_nxt.rdat[`RTSQ_POWER_CONTROL_FLAGS_BOR] = q_r.bor_flag;
               q_nxt.rdat[`RTSQ_POWER_CONTROL_FLAGS_POR] = q_r.por_flag;
               q_nxt.rdat[`RTSQ_POWER_CONTROL_FLAGS_SOFT_BROWNOUT_ENABLE] = q_r.soft_brownout_enable;
               q_nxt.rdat[`RTSQ_POWER_CONTROL_FLAGS_ULTRA_LOW_WAKE_ENABLE] = q_r.ultra_low_wake_enable;
            end
            `RTSQ_ADDR_STATUS: begin
               q_nxt.rdat[`RTSQ_STAT_TO] = q_r.to_flag;
               q_nxt.rdat[`RTSQ_STAT_PD] = q_r.pd_flag;
            end
            `RTSQ_ADDR_CONFIG: q_nxt.rdat[15:0] = q_r.cfg;
            `RTSQ_ADDR_CAUSE: begin
               q_nxt.rdat[2:0] = q_r.cause;
               q_nxt.rdat[10:8] = q_r.st;
            end
            default: q_nxt.rdat = '0;
         endcase
      end
      // Status writes accepted but read-only flags stay hardware owned
      if (wr_stat) begin
         q_nxt.rdat = q_nxt.rdat;
      end
   end

   // Single state register; rst_i models the power-on event
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_r <= '0;
         q_r.s1 <= '1;
         q_r.s2 <= '1;
         q_r.cfg <= `RTSQ_CFG_RESET;
         q_r.pwr_event <= 1'b1;
         q_r.to_flag <= 1'b1;
         q_r.pd_flag <= 1'b1;
         q_r.soft_brownout_enable <= 1'b1;
         q_r.st <= RTSQ_HOLD;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Core reset ignores the pin during time-outs other than a two-speed crystal count, then follows it
   assign core_reset_o = (q_r.st != RTSQ_RUN && q_r.st != RTSQ_SLEEP &&
                          !(q_r.st == RTSQ_OST && core_run_fast_o)) ||
                         !q_r.s2.external_reset_pin_n;
   // Two-speed or fail-safe lets the core run during CRYSTAL_STARTUP_COUNT
   assign core_run_fast_o = (q_r.st == RTSQ_OST) &&
                            (q_r.cfg[`RTSQ_CFG_IESO] |
                             q_r.cfg[`RTSQ_CFG_FCMEN]);
   assign sleeping_o = (q_r.st == RTSQ_SLEEP);
   assign bod_enabled_o = bod_en;
   assign wb_dat_o = q_r.rdat;
   assign wb_ack_o = q_r.ack;
   assign wb_err_o = q_r.err;
endmodule

// File: rtsq_params.svh
`ifndef RTSQ_PARAMS_SVH
`define RTSQ_PARAMS_SVH
// Register byte addresses on the Wishbone bus
`define RTSQ_ADDR_PWRCTL 8'h8E
`define RTSQ_ADDR_STATUS 8'h8C
`define RTSQ_ADDR_CONFIG 8'h90
`define RTSQ_ADDR_CAUSE 8'h94
// Field positions in the power control register
`define RTSQ_POWER_CONTROL_FLAGS_BOR 0
`define RTSQ_POWER_CONTROL_FLAGS_POR 1
`define RTSQ_POWER_CONTROL_FLAGS_SOFT_BROWNOUT_ENABLE 4
`define RTSQ_POWER_CONTROL_FLAGS_ULTRA_LOW_WAKE_ENABLE 5
// Field positions in the core status register
`define RTSQ_STAT_PD 3
`define RTSQ_STAT_TO 4
// Field positions in the configuration register
`define RTSQ_CFG_OSC_LSB 0
`define RTSQ_CFG_SUPPLY_TIMER_DISABLE_BIT 4
`define RTSQ_CFG_BROWNOUT_MODE_SELECT_LSB 8
`define RTSQ_CFG_IESO 10
`define RTSQ_CFG_FCMEN 11
// Configuration reset value: timer enabled, brown-out always on, fast crystal
`define RTSQ_CFG_RESET 16'h0302
// Timing: 200 MHz core clock, 31 kHz slow oscillator
`define RTSQ_CLK_HZ 200000000
`define RTSQ_SLOW_HZ 31000
`define RTSQ_SLOW_DIV ((`RTSQ_CLK_HZ) / (`RTSQ_SLOW_HZ))
`define RTSQ_SETTLE_MS 64
`define RTSQ_SETTLE_TICKS (((`RTSQ_SETTLE_MS) * (`RTSQ_SLOW_HZ)) / 1000)
`define RTSQ_OST_PERIODS 1024
`define RTSQ_BOD_MIN_CYC 16
`endif

// File: rtsq_pkg.sv
package rtsq_pkg;
   typedef enum logic [2:0] {
      RTSQ_HOLD = 3'h0,
      RTSQ_SETTLE = 3'h1,
      RTSQ_OST = 3'h2,
      RTSQ_RUN = 3'h3,
      RTSQ_SLEEP = 3'h4
   } rtsq_state_type;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic we;
      logic [3:0] sel;
      logic cyc;
      logic stb;
   } rtsq_wb_req_type;

   typedef struct packed {
      logic por_n;
      logic bod;
      logic external_reset_pin_n;
      logic wdt_reset;
      logic wdt_wake;
      logic int_wake;
      logic sleep_req;
      logic osc_tick;
   } rtsq_pins_type;
endpackage

// File: rtsq_sequencer_checker.sv
`timescale 1ns/1ps
module rtsq_sequencer_checker #(
   parameter int SETTLE_TICKS = 4,
   parameter int SLOW_DIV = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_n_i,
   input wire logic bod_i,
   input wire logic external_reset_pin_n_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic core_reset_o,
   input wire logic bod_enabled_o
);
   logic [15:0] span_r;
   logic [4:0] bod_r;
   logic req;
   // Saturating counts: cycles since power-on, enabled brown-out length
   always_ff @(posedge clk_i) begin
      span_r <= (rst_i || !por_n_i) ? 16'h0 : span_r + {15'h0, ~&span_r};
      bod_r <= (bod_i && bod_enabled_o) ? bod_r + {4'h0, ~&bod_r} : 5'h0;
   end
   // A new request is one not already answered
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_timely: assert property (req |=> wb_ack_o || wb_err_o)
      else $error("request not answered next cycle");
   a_no_stray: assert property (!(wb_cyc_i && wb_stb_i) |=>
      !wb_ack_o && !wb_err_o)
      else $error("answer without request");
   a_err_unmapped: assert property (req && !(wb_adr_i inside
      {8'h8C, 8'h8E, 8'h90, 8'h94}) |=> wb_err_o && !wb_ack_o)
      else $error("unmapped address not refused");
   a_bod_resets: assert property (bod_r >= 5'h18 |-> core_reset_o)
      else $error("long brown-out did not reset");
   a_external_reset_pin_holds: assert property (!external_reset_pin_n_i [*4] |-> core_reset_o)
      else $error("core runs with reset pin low");
   a_release_clean: assert property ($fell(core_reset_o) |->
      $past(external_reset_pin_n_i, 2) && !($past(bod_i, 3) && $past(bod_enabled_o, 3)))
      else $error("release while supply or pin bad");
   a_settle_span: assert property ($fell(core_reset_o) |->
      span_r > 16'(SETTLE_TICKS * SLOW_DIV))
      else $error("release before settle time");
endmodule

// File: rtsq_sequencer_test.sv
`timescale 1ns/1ps
module rtsq_sequencer_test
   import rtsq_pkg::*;
;
   logic clk_i;
   logic rst_i;
   rtsq_pins_type pins;
   rtsq_wb_req_type req;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic wb_err_o;
   logic core_reset_o;
   logic core_run_fast_o;
   logic sleeping_o;
   logic bod_enabled_o;
   logic [31:0] q;
   logic e;
   int n_mismatch;
   int n_compared;
   int cyc_cnt;
   int t;
   // Short settle so a power-up takes a few thousand cycles
   rtsq_sequencer #(.SETTLE_TICKS(4), .SLOW_DIV(3)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .por_n_i(pins.por_n), .bod_i(pins.bod),
      .external_reset_pin_n_i(pins.external_reset_pin_n), .wdt_reset_i(pins.wdt_reset),
      .wdt_wake_i(pins.wdt_wake), .int_wake_i(pins.int_wake),
      .sleep_req_i(pins.sleep_req), .osc_tick_i(pins.osc_tick),
      .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_we_i(req.we),
      .wb_sel_i(req.sel), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .core_reset_o(core_reset_o), .core_run_fast_o(core_run_fast_o),
      .sleeping_o(sleeping_o), .bod_enabled_o(bod_enabled_o));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Crystal ticks every four clocks; a hang ends at the cycle ceiling
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      pins.osc_tick <= cyc_cnt[1];
      if (cyc_cnt == 40000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] x,
         input logic [31:0] g);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One classic cycle; waits for ack or err, no fixed latency assumed
   task automatic bus(input logic [7:0] a, input logic w,
         input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      req <= '{a, d, w, s, 1'b1, 1'b1};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      e = wb_err_o;
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a);
      bus(a, 1'b0, 32'h0, 4'hF);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      bus(a, 1'b1, d, s);
   endtask
   // Cycles until the core leaves reset
   task automatic wait_rel();
      for (t = 0; t < 9000 && core_reset_o !== 1'b0; t++) @(posedge clk_i);
   endtask
   task automatic t_power_on();
      wait_rel();
      chk("power-up time", 1, t inside {[4100:4300]});
      rd(8'h8E);
      chk("power-on flag", 0, q[1]);
      rd(8'h8C);
      chk("status after power-on", 2'h3, q[4:3]);
      $display("power-on test done");
   endtask
   task automatic t_brownout();
      wr(8'h8E, 32'h13, 4'h1);
      pins.bod <= 1'b1;
      cycles(40);
      chk("reset in brown-out", 1, core_reset_o);
      pins.bod <= 1'b0;
      cycles(10);
      pins.bod <= 1'b1;
      cycles(40);
      pins.bod <= 1'b0;
      wait_rel();
      chk("brown-out time", 1, t inside {[4100:4300]});
      rd(8'h8E);
      chk("flags after brown-out", 2'h2, q[1:0]);
      $display("brown-out test done");
   endtask
   task automatic t_no_timer();
      wr(8'h90, 32'h0313, 4'h3);
      pins.bod <= 1'b1;
      cycles(40);
      pins.bod <= 1'b0;
      wait_rel();
      chk("untimed release", 1, t < 16);
      pins.external_reset_pin_n <= 1'b0;
      cycles(10);
      pins.external_reset_pin_n <= 1'b1;
      wait_rel();
      rd(8'h8E);
      chk("flags after pin reset", 2'h2, q[1:0]);
      rd(8'h8C);
      chk("status after pin reset", 2'h3, q[4:3]);
      pins.wdt_reset <= 1'b1;
      cycles(6);
      pins.wdt_reset <= 1'b0;
      wait_rel();
      rd(8'h8C);
      chk("status after watchdog", 2'h1, q[4:3]);
      rd(8'h00);
      chk("unmapped refused", 1, e);
      $display("untimed test done");
   endtask
   task automatic t_modes();
      for (int m = 0; m < 8; m++) begin
         wr(8'h90, 32'h0013 | ((m >> 1) << 8), 4'h3);
         wr(8'h8E, {27'h0, m[0], 4'h3}, 4'h1);
         cycles(4);
         chk("bod enable", m[2] | (m[2:1] == 2'h1 && m[0]),
            bod_enabled_o);
      end
      $display("mode test done");
   endtask
   task automatic t_sleep();
      wr(8'h90, 32'h0213, 4'h3);
      for (int k = 0; k < 2; k++) begin
         pins.sleep_req <= 1'b1;
         cycles(6);
         chk("asleep", 1, sleeping_o);
         chk("bod off in sleep", 0, bod_enabled_o);
         pins.sleep_req <= 1'b0;
         pins.wdt_wake <= !k[0];
         pins.external_reset_pin_n <= !k[0];
         cycles(6);
         pins.wdt_wake <= 1'b0;
         pins.external_reset_pin_n <= 1'b1;
         wait_rel();
         chk("woken bod on", 1, bod_enabled_o);
         chk("wake time", 1, t < 16);
         rd(8'h8C);
         chk("status after wake", {k[0], 1'b0}, q[4:3]);
      end
      $display("sleep test done");
   endtask
   task automatic t_late_pin();
      wr(8'h90, 32'h0302, 4'h3);
      pins.external_reset_pin_n <= 1'b0;
      pins.por_n <= 1'b0;
      cycles(10);
      pins.por_n <= 1'b1;
      cycles(5000);
      pins.external_reset_pin_n <= 1'b1;
      wait_rel();
      chk("late pin release", 1, t < 8);
      $display("late pin test done");
   endtask
   // Switchover lets the core run on the fast oscillator during the count
   task automatic t_two_speed();
      wr(8'h90, 32'h0702, 4'h3);
      pins.por_n <= 1'b0;
      cycles(10);
      pins.por_n <= 1'b1;
      cycles(100);
      chk("fast run in count", 1, core_run_fast_o);
      chk("core free in count", 0, core_reset_o);
      cycles(4300);
      chk("fast run ends", 0, core_run_fast_o);
      chk("core free after count", 0, core_reset_o);
      $display("two-speed test done");
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_i = 1'b1;
      pins = '{por_n: 1'b1, external_reset_pin_n: 1'b1, default: 1'b0};
      req = '0;
      n_mismatch = 0;
      n_compared = 0;
      cyc_cnt = 0;
      cycles(10);
      rst_i <= 1'b0;
      t_power_on();
      t_brownout();
      t_no_timer();
      t_modes();
      t_sleep();
      t_late_pin();
      t_two_speed();
      tally_and_finish();
   end
endmodule
bind rtsq_sequencer rtsq_sequencer_checker #(.SETTLE_TICKS(SETTLE_TICKS),
   .SLOW_DIV(SLOW_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .por_n_i(por_n_i), .bod_i(bod_i), .external_reset_pin_n_i(external_reset_pin_n_i),
   .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .core_reset_o(core_reset_o), .bod_enabled_o(bod_enabled_o));
